// [pcdcl_defs.svh]
// How it works
// - The aux power enable bit 10 always reads zero and ignores writes.
// - Phantom function enable bit 9 is fixed at zero and reads zero.
// - Extended tag enable bit 8 is fixed at zero and reads zero.
// - Size code bits 7:5, 000 to 101 mean 128 to 4096 bytes, reset 000.
// - Relaxed ordering enable bit 4 is fixed at zero and reads zero.
// - Unsupported requests send nonfatal messages only if bit 3 is set.
// - System error events send fatal messages only if bit 2 is set.
// - System error events send nonfatal messages only if bit 1 is set.
// - System error events send correctable messages only if bit 0 is set.
`ifndef PCDCL_DEFS_SVH
`define PCDCL_DEFS_SVH
`define PCDCL_DEVCTL_OFFSET 12'h098
`define PCDCL_AUXPM_BIT     10
`define PCDCL_PHANTOM_BIT   9
`define PCDCL_EXTTAG_BIT    8
`define PCDCL_MPS_MSB       7
`define PCDCL_MPS_LSB       5
`define PCDCL_RELAX_BIT     4
`define PCDCL_UR_BIT        3
`define PCDCL_FATAL_BIT     2
`define PCDCL_NONFATAL_BIT  1
`define PCDCL_CORR_BIT      0
`define PCDCL_MPS_RESET     3'h0
`define PCDCL_MPS_MAXCODE   3'h5
`define PCDCL_ENABLE_RESET  1'b0
`define PCDCL_LOW_BYTE_LANE 0
`define PCDCL_BYTES_BASE    13'h0080
`endif

// [pcdcl_device_control.sv]
`timescale 1ns/10ps
`include "pcdcl_defs.svh"
module pcdcl_device_control (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic [11:0] cfgAddr,
	input  wire logic        cfgWrite,
	input  wire logic        cfgRead,
	input  wire logic [1:0]  cfgByteEn,
	input  wire logic [15:0] cfgWriteData,
	output logic [10:0]      cfgReadData,
	output logic             cfgReadValid,
	output logic [2:0]       maxPayloadSize,
	output logic [12:0]      maxPayloadBytes,
	input  wire logic        urEvent,
	input  wire logic        fatalEvent,
	input  wire logic        nonfatalEvent,
	input  wire logic        corrEvent,
	output logic             msgFatal,
	output logic             msgNonfatal,
	output logic             msgCorr
);
	pcdcl_pkg::pcdcl_mps_type   mps_reg;
	logic                       urEn_reg;
	logic                       fatalEn_reg;
	logic                       nonfatalEn_reg;
	logic                       corrEn_reg;
	pcdcl_pkg::pcdcl_ctl_type   ctlValue;
	pcdcl_pkg::pcdcl_ctl_type   readData_reg;
	logic                       readValid_reg;
	pcdcl_pkg::pcdcl_bytes_type bytes_reg;
	logic                       hit;
	logic                       lowWrite;

	pcdcl_err_if errIf ();

	assign hit      = (cfgAddr == `PCDCL_DEVCTL_OFFSET);
	// Only the low byte lane holds writable bits; the upper lane is all fixed.
	assign lowWrite = cfgWrite & hit & cfgByteEn[`PCDCL_LOW_BYTE_LANE];

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mps_reg <= `PCDCL_MPS_RESET;
		end else if (ce && lowWrite) begin
			mps_reg <= cfgWriteData[`PCDCL_MPS_MSB:`PCDCL_MPS_LSB];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			urEn_reg       <= `PCDCL_ENABLE_RESET;
			fatalEn_reg    <= `PCDCL_ENABLE_RESET;
			nonfatalEn_reg <= `PCDCL_ENABLE_RESET;
			corrEn_reg     <= `PCDCL_ENABLE_RESET;
		end else if (ce && lowWrite) begin
			urEn_reg       <= cfgWriteData[`PCDCL_UR_BIT];
			fatalEn_reg    <= cfgWriteData[`PCDCL_FATAL_BIT];
			nonfatalEn_reg <= cfgWriteData[`PCDCL_NONFATAL_BIT];
			corrEn_reg     <= cfgWriteData[`PCDCL_CORR_BIT];
		end
	end

	always_comb begin
		ctlValue = '0;
		ctlValue[`PCDCL_AUXPM_BIT]   = 1'b0;
		ctlValue[`PCDCL_PHANTOM_BIT] = 1'b0;
		ctlValue[`PCDCL_EXTTAG_BIT]  = 1'b0;
		ctlValue[`PCDCL_MPS_MSB:`PCDCL_MPS_LSB] = mps_reg;
		ctlValue[`PCDCL_RELAX_BIT]   = 1'b0;
		ctlValue[`PCDCL_UR_BIT]       = urEn_reg;
		ctlValue[`PCDCL_FATAL_BIT]    = fatalEn_reg;
		ctlValue[`PCDCL_NONFATAL_BIT] = nonfatalEn_reg;
		ctlValue[`PCDCL_CORR_BIT]     = corrEn_reg;
	end

	// Reads of other offsets answer zero so a shared read mux can OR us in.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			readData_reg  <= '0;
			readValid_reg <= 1'b0;
		end else if (ce) begin
			readValid_reg <= cfgRead;
			readData_reg  <= (cfgRead && hit) ? ctlValue : '0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bytes_reg <= `PCDCL_BYTES_BASE;
		end else if (ce) begin
			bytes_reg <= pcdcl_pkg::pcdcl_mps_bytes(mps_reg);
		end
	end

	assign errIf.urEnable       = urEn_reg;
	assign errIf.fatalEnable    = fatalEn_reg;
	assign errIf.nonfatalEnable = nonfatalEn_reg;
	assign errIf.corrEnable     = corrEn_reg;

	pcdcl_err_msg msgGen (
		.mclk          (mclk),
		.reset         (reset),
		.ce            (ce),
		.enables       (errIf),
		.urEvent       (urEvent),
		.fatalEvent    (fatalEvent),
		.nonfatalEvent (nonfatalEvent),
		.corrEvent     (corrEvent),
		.msgFatal      (msgFatal),
		.msgNonfatal   (msgNonfatal),
		.msgCorr       (msgCorr)
	);

	assign cfgReadData     = readData_reg;
	assign cfgReadValid    = readValid_reg;
	assign maxPayloadSize  = mps_reg;
	assign maxPayloadBytes = bytes_reg;

	fixed_bits_a: assert property (@(posedge mclk) disable iff (reset)
		cfgReadValid |-> (cfgReadData[`PCDCL_AUXPM_BIT:`PCDCL_EXTTAG_BIT] == 3'h0
			&& !cfgReadData[`PCDCL_RELAX_BIT]))
		else $error("A fixed zero bit reads as one.");
	phantom_zero_a: assert property (@(posedge mclk) disable iff (reset)
		(ce && cfgRead && hit) |=> !cfgReadData[`PCDCL_PHANTOM_BIT])
		else $error("Phantom function bit reads as one.");
	exttag_zero_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite && cfgWriteData[`PCDCL_EXTTAG_BIT])
		##1 (ce && cfgRead && hit)
		|=> !cfgReadData[`PCDCL_EXTTAG_BIT])
		else $error("Extended tag bit took a write.");
	mps_write_a: assert property (@(posedge mclk) disable iff (reset)
		(ce && lowWrite) |=> (maxPayloadSize ==
			$past(cfgWriteData[`PCDCL_MPS_MSB:`PCDCL_MPS_LSB])))
		else $error("Payload size field did not take the write.");
	mps_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!(ce && lowWrite) |=> $stable(maxPayloadSize))
		else $error("Payload size changed without a write.");
	relax_zero_a: assert property (@(posedge mclk) disable iff (reset)
		(ce && cfgRead && hit) |=> !cfgReadData[`PCDCL_RELAX_BIT])
		else $error("Relaxed ordering bit reads as one.");
	enable_readback_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite) ##1 (ce && cfgRead && hit && !cfgWrite)
		|=> (cfgReadData[`PCDCL_UR_BIT:`PCDCL_CORR_BIT] ==
			$past(cfgWriteData[`PCDCL_UR_BIT:`PCDCL_CORR_BIT], 2)))
		else $error("Report enables do not read back the last write.");
	upper_lane_a: assert property (@(posedge mclk) disable iff (reset)
		(ce && cfgWrite && hit && !cfgByteEn[`PCDCL_LOW_BYTE_LANE])
		|=> $stable({urEn_reg, fatalEn_reg, nonfatalEn_reg, corrEn_reg, mps_reg}))
		else $error("Upper lane write altered an enable.");
	read_valid_a: assert property (
		@(posedge mclk) disable iff (reset)
		ce |=> (cfgReadValid == $past(cfgRead)))
		else $error("Read valid does not follow the read request.");
	miss_read_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && cfgRead && !hit) |=> (cfgReadData == '0))
		else $error("A read of another offset returned data.");
	ce_freeze_a: assert property (
		@(posedge mclk) disable iff (reset)
		!ce |=> ($stable(ctlValue) && $stable(cfgReadData)
			&& $stable(cfgReadValid) && $stable(maxPayloadBytes)))
		else $error("State moved while the clock enable was low.");
	field_read_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && cfgRead && hit) |=>
			(cfgReadData[`PCDCL_MPS_MSB:`PCDCL_MPS_LSB] == $past(maxPayloadSize)))
		else $error("Payload size field does not read back.");
	bytes_decode_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && maxPayloadSize <= `PCDCL_MPS_MAXCODE) |=>
			(maxPayloadBytes == (`PCDCL_BYTES_BASE << $past(maxPayloadSize))))
		else $error("Payload byte count does not match its code.");
	bytes_reserved_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && maxPayloadSize > `PCDCL_MPS_MAXCODE) |=>
			(maxPayloadBytes == `PCDCL_BYTES_BASE))
		else $error("Reserved payload code did not give the smallest size.");
	aux_write_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite && cfgWriteData[`PCDCL_AUXPM_BIT])
		##1 (ce && cfgRead && hit) |=> !cfgReadData[`PCDCL_AUXPM_BIT])
		else $error("Aux power enable bit took a write.");
	phantom_write_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite && cfgWriteData[`PCDCL_PHANTOM_BIT])
		##1 (ce && cfgRead && hit) |=> !cfgReadData[`PCDCL_PHANTOM_BIT])
		else $error("Phantom function bit took a write.");
	relax_write_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite && cfgWriteData[`PCDCL_RELAX_BIT])
		##1 (ce && cfgRead && hit) |=> !cfgReadData[`PCDCL_RELAX_BIT])
		else $error("Relaxed ordering bit took a write.");
	ur_write_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite) |=>
			(urEn_reg == $past(cfgWriteData[`PCDCL_UR_BIT])))
		else $error("Unsupported request enable did not take the write.");
	fatal_write_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite) |=>
			(fatalEn_reg == $past(cfgWriteData[`PCDCL_FATAL_BIT])))
		else $error("Fatal report enable did not take the write.");
	nonfatal_write_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite) |=>
			(nonfatalEn_reg == $past(cfgWriteData[`PCDCL_NONFATAL_BIT])))
		else $error("Nonfatal report enable did not take the write.");
	corr_write_a: assert property (
		@(posedge mclk) disable iff (reset)
		(ce && lowWrite) |=>
			(corrEn_reg == $past(cfgWriteData[`PCDCL_CORR_BIT])))
		else $error("Correctable report enable did not take the write.");
endmodule : pcdcl_device_control

// [pcdcl_err_if.sv]
`timescale 1ns/10ps
interface pcdcl_err_if;
	logic urEnable;
	logic fatalEnable;
	logic nonfatalEnable;
	logic corrEnable;
	modport ctrl (output urEnable, output fatalEnable,
		output nonfatalEnable, output corrEnable);
	modport gen (input urEnable, input fatalEnable,
		input nonfatalEnable, input corrEnable);
endinterface : pcdcl_err_if

// [pcdcl_err_msg.sv]
`timescale 1ns/10ps
`include "pcdcl_defs.svh"
module pcdcl_err_msg (
	input  wire logic  mclk,
	input  wire logic  reset,
	input  wire logic  ce,
	pcdcl_err_if.gen   enables,
	input  wire logic  urEvent,
	input  wire logic  fatalEvent,
	input  wire logic  nonfatalEvent,
	input  wire logic  corrEvent,
	output logic       msgFatal,
	output logic       msgNonfatal,
	output logic       msgCorr
);
	logic msgFatal_reg;
	logic msgNonfatal_reg;
	logic msgCorr_reg;
	logic msgNonfatal_next;

	// An unsupported request and a nonfatal event in one cycle share one message.
	always_comb begin
		msgNonfatal_next = (urEvent & enables.urEnable) |
			(nonfatalEvent & enables.nonfatalEnable);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			msgFatal_reg    <= 1'b0;
			msgNonfatal_reg <= 1'b0;
			msgCorr_reg     <= 1'b0;
		end else if (ce) begin
			msgFatal_reg    <= fatalEvent & enables.fatalEnable;
			msgNonfatal_reg <= msgNonfatal_next;
			msgCorr_reg     <= corrEvent & enables.corrEnable;
		end
	end

	assign msgFatal    = msgFatal_reg;
	assign msgNonfatal = msgNonfatal_reg;
	assign msgCorr     = msgCorr_reg;

	fatal_gate_a: assert property (@(posedge mclk) disable iff (reset)
		ce |=> (msgFatal == $past(fatalEvent & enables.fatalEnable)))
		else $error("Fatal message does not follow its gated event.");
	corr_gate_a: assert property (@(posedge mclk) disable iff (reset)
		(ce && !enables.corrEnable) |=> !msgCorr)
		else $error("Correctable message sent while disabled.");
	ur_report_a: assert property (@(posedge mclk) disable iff (reset)
		(ce && urEvent && enables.urEnable) |=> msgNonfatal)
		else $error("Unsupported request was not reported.");
	nonfatal_gate_a: assert property (@(posedge mclk) disable iff (reset)
		(ce && !(urEvent && enables.urEnable) && !enables.nonfatalEnable)
		|=> !msgNonfatal)
		else $error("Nonfatal message sent while disabled.");
endmodule : pcdcl_err_msg

// [pcdcl_msg_sink.sv]
`timescale 1ns/10ps
module pcdcl_msg_sink (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic msgFatal,
	input  wire logic msgNonfatal,
	input  wire logic msgCorr,
	output int        fatalCount,
	output int        nonfatalCount,
	output int        corrCount
);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fatalCount <= 0;
			nonfatalCount <= 0;
			corrCount <= 0;
		end else begin
			fatalCount <= fatalCount + int'(msgFatal);
			nonfatalCount <= nonfatalCount + int'(msgNonfatal);
			corrCount <= corrCount + int'(msgCorr);
		end
	end
endmodule : pcdcl_msg_sink

// [pcdcl_pkg.sv]
`include "pcdcl_defs.svh"
package pcdcl_pkg;
	typedef logic [2:0]  pcdcl_mps_type;
	typedef logic [10:0] pcdcl_ctl_type;
	typedef logic [12:0] pcdcl_bytes_type;

	// Reserved codes fall back to the smallest size so a bad write stays safe.
	function automatic pcdcl_bytes_type pcdcl_mps_bytes(input pcdcl_mps_type code);
		if (code > `PCDCL_MPS_MAXCODE) begin
			return `PCDCL_BYTES_BASE;
		end
		return pcdcl_bytes_type'(`PCDCL_BYTES_BASE << code);
	endfunction : pcdcl_mps_bytes
endpackage : pcdcl_pkg

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
	logic        mclk, reset, ce, cfgWrite, cfgRead, cfgReadValid;
	logic [11:0] cfgAddr;
	logic [1:0]  cfgByteEn;
	logic [15:0] cfgWriteData;
	logic [10:0] cfgReadData;
	logic [2:0]  maxPayloadSize;
	logic [12:0] maxPayloadBytes;
	logic        urEvent, fatalEvent, nonfatalEvent, corrEvent;
	logic        msgFatal, msgNonfatal, msgCorr;
	int          fatalCount, nonfatalCount, corrCount;
	int          fail_count, n_tests, cycles, mpsM, enM, nF, nN, nC, r;
	pcdcl_device_control pcdcl_device_control_inst (.mclk(mclk),
		.reset(reset), .ce(ce), .cfgAddr(cfgAddr), .cfgWrite(cfgWrite),
		.cfgRead(cfgRead), .cfgByteEn(cfgByteEn),
		.cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
		.cfgReadValid(cfgReadValid), .maxPayloadSize(maxPayloadSize),
		.maxPayloadBytes(maxPayloadBytes), .urEvent(urEvent),
		.fatalEvent(fatalEvent), .nonfatalEvent(nonfatalEvent),
		.corrEvent(corrEvent), .msgFatal(msgFatal),
		.msgNonfatal(msgNonfatal), .msgCorr(msgCorr));
	pcdcl_msg_sink pcdcl_msg_sink_inst (.mclk(mclk), .reset(reset),
		.msgFatal(msgFatal), .msgNonfatal(msgNonfatal), .msgCorr(msgCorr),
		.fatalCount(fatalCount), .nonfatalCount(nonfatalCount),
		.corrCount(corrCount));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic tick;
		@(posedge mclk);
		#2;
	endtask : tick
	task automatic wr(input logic [11:0] a, input logic [1:0] be,
		input logic [15:0] d);
		cfgAddr = a;
		cfgByteEn = be;
		cfgWriteData = d;
		cfgWrite = 1'b1;
		tick();
		cfgWrite = 1'b0;
		if (a == 12'h098 && be[0] && ce) begin
			mpsM = d[7:5];
			enM = d[3:0];
		end
	endtask : wr
	task automatic rd(input logic [11:0] a);
		cfgAddr = a;
		cfgRead = 1'b1;
		tick();
		cfgRead = 1'b0;
		check(cfgReadValid, 16'h0001);
		check(cfgReadData, (a == 12'h098) ? 16'((mpsM << 5) | enM) : 0);
		check(maxPayloadSize, 16'(mpsM));
		check(maxPayloadBytes, (mpsM > 5) ? 16'h0080 : 16'(128 << mpsM));
	endtask : rd
	task automatic ev(input logic [3:0] e);
		{urEvent, fatalEvent, nonfatalEvent, corrEvent} = e;
		tick();
		{urEvent, fatalEvent, nonfatalEvent, corrEvent} = 4'h0;
		nF += e[2] & enM[2];
		nN += (e[3] & enM[3]) | (e[1] & enM[1]);
		nC += e[0] & enM[0];
		check(msgFatal, 16'(e[2] & enM[2]));
		check(msgNonfatal, 16'((e[3] & enM[3]) | (e[1] & enM[1])));
		check(msgCorr, 16'(e[0] & enM[0]));
	endtask : ev
	always @(posedge mclk) begin
		cycles++;
		if (cycles >= 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(32'h7471_4164));
		{ce, cfgWrite, cfgRead, cfgAddr, cfgByteEn, cfgWriteData} = '0;
		{urEvent, fatalEvent, nonfatalEvent, corrEvent} = 4'h0;
		{fail_count, n_tests, cycles, mpsM, enM, nF, nN, nC} = '0;
		reset = 1'b1;
		ce = 1'b1;
		repeat (20) @(posedge mclk);
		#2 reset = 1'b0;
		rd(12'h098);
		ev(4'hF);
		wr(12'h098, 2'b11, 16'hFFFF);
		rd(12'h098);
		wr(12'h098, 2'b10, 16'h0000);
		rd(12'h09A);
		ce = 1'b0;
		wr(12'h098, 2'b01, 16'h0000);
		ce = 1'b1;
		rd(12'h098);
		for (int i = 0; i < 8; i++) begin
			wr(12'h098, 2'b01, 16'(i << 5) | 16'($urandom % 16));
			rd(12'h098);
		end
		for (int i = 0; i < 200; i++) begin
			r = $urandom;
			wr((r[0]) ? 12'h098 : 12'h09A, r[2:1], r[31:16]);
			ev(r[7:4]);
			if (r[8]) rd(12'h098);
		end
		tick();
		check(16'(fatalCount), 16'(nF));
		check(16'(nonfatalCount), 16'(nN));
		check(16'(corrCount), 16'(nC));
		tally_and_finish();
	end
endmodule : testbench
